//--- design/csp_pkg.sv
// Purpose: Shared constants and types for the clock source and PLL control block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes: Register offsets are chosen for this block
package csp_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] CSP_OFF_MAIN = 8'h00;
	localparam logic [7:0] CSP_OFF_TRIM = 8'h04;
	localparam logic [7:0] CSP_OFF_SUPPLY = 8'h08;
	localparam logic [7:0] CSP_OFF_PLL_TEST_REG = 8'h0C;
	localparam logic [7:0] CSP_OFF_CAL5_HI = 8'h10;
	localparam logic [7:0] CSP_OFF_CAL5_LO = 8'h14;
	localparam logic [7:0] CSP_OFF_CAL33_HI = 8'h18;
	localparam logic [7:0] CSP_OFF_CAL33_LO = 8'h1C;
	localparam logic [7:0] CSP_OFF_STATUS = 8'h20;
	// ==========================================================
	// Field positions and reset values
	localparam int CSP_MAIN_SLOW = 0;
	localparam int CSP_MAIN_CLKOUT = 1;
	localparam int CSP_SUP_SETTLED = 0;
	localparam int CSP_SUP_TRIM_LSB = 5;
	localparam int CSP_PLL_TEST_REG_HALF = 0;
	localparam logic [7:0] CSP_MAIN_RST = 8'h00;
	localparam logic [7:0] CSP_TRIM_RST = 8'hFF;
	localparam logic [1:0] CSP_TRIM_LO_RST = 2'h0;
	localparam logic [7:0] CSP_MAIN_WMASK = 8'h03;
	localparam logic [1:0] CSP_RESP_OKAY = 2'h0;
	localparam logic [1:0] CSP_RESP_SLVERR = 2'h2;
	// ==========================================================
	// Dividers and timing
	localparam int CSP_SLOW_DIV = 32;
	localparam int CSP_TIMER_IN_DIV = 2;
	localparam int CSP_MUL_LOW = 4;
	localparam int CSP_MUL_HIGH = 8;
	localparam int CSP_CLK_MHZ = 200;
	localparam int CSP_STARTUP_US = 1;
	localparam int CSP_STARTUP_CYC = CSP_STARTUP_US * CSP_CLK_MHZ;
	localparam int CSP_DIV_W = 5;
	// ==========================================================
	// Option byte clock source codes
	typedef enum logic [2:0] {
		CSP_SRC_EXT = 3'h0,
		CSP_SRC_XTAL0 = 3'h1,
		CSP_SRC_XTAL1 = 3'h2,
		CSP_SRC_XTAL2 = 3'h3,
		CSP_SRC_XTAL3 = 3'h4,
		CSP_SRC_XTAL4 = 3'h5,
		CSP_SRC_RC = 3'h6,
		CSP_SRC_PIN = 3'h7
	} csp_src_e;
	typedef struct packed {
		csp_src_e src;
		logic pll_en;
		logic pll_x8;
		logic tpll_en;
		logic ext16;
	} csp_opt_s;
	typedef enum logic [2:0] {
		CSP_ST_OFF = 3'b001,
		CSP_ST_WAIT = 3'b010,
		CSP_ST_LOCK = 3'b100
	} csp_pll_e;
	// ==========================================================
	// Factory trim reorder into stored layout
	function automatic logic [7:0] csp_lo_byte(input logic [1:0] lo);
		csp_lo_byte = {1'b0, lo, 5'h00};
	endfunction
endpackage

//--- design/csp_divider.sv
// Purpose: Clock-enable divider for one source tick stream
// Assumes: Single clock domain, tick marks one source edge
// Notes: Produces one pulse every DIV input ticks
module csp_divider import csp_pkg::*; #(
	parameter int DIV = 32,
	parameter int W = 5
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Ticks
	input wire logic tick_in,
	output logic tick_out
);
	localparam logic [W-1:0] LAST = W'(DIV - 1);
	logic [W-1:0] count;
	// ==========================================================
	// Counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= '0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= 1'b0;
			if (tick_in) begin
				if (count == LAST) begin
					count <= '0;
					tick_out <= 1'b1;
				end else begin
					count <= count + W'(1);
				end
			end
		end
	end
endmodule

//--- design/csp_top.sv
// Purpose: Clock source selection, PLL control, slow mode and RC trim registers
// Assumes: Source clocks arrive as slow levels, synchronised and edge-detected on aclk; option byte is static
// Notes: Analog oscillators and PLL loops are outside; this is their control
//
// Operation
// R01 - RC trim is ten bits: eight in trim register, two in supply bits 6:5.
// R02 - Every reset restores the trim register to FFh.
// R03 - Trim code monotonic: 00h fastest, FFh slowest frequency.
// R04 - Factory trims for 5V and 3.3V readable only, high and low bytes.
// R05 - Stored low trim byte holds its two bits at positions 5 and 6.
// R06 - Main PLL multiplies 1 MHz RC or external by 4 or 8.
// R07 - PLL off and RC on: oscillator clock is the RC output.
// R08 - RC and PLL both off: oscillator clock is external input.
// R09 - Settled flag set once PLL output reaches operating frequency.
// R10 - RC with x8 and halving bit set gives 4 MHz.
// R11 - Timer PLL multiplies 8 MHz by 4 for the timer only.
// R12 - A 16 MHz source is divided by 2 to feed the timer PLL.
// R13 - Main clock register bits 7:2 read zero; reset value 00h.
// R14 - Main register bit 1 enables clock output, else pin is plain I/O.
// R15 - Main register bit 0 selects oscillator clock divided by 32.
// R16 - Software tunes trim by binary search starting at 80h.
// R17 - Programming mode forces RC as source regardless of option byte.
// R18 - Parts without RC use tool-supplied clock in programming mode.
// R19 - Crystal oscillator keeps running through reset.
// R20 - Without multi-oscillator, designated pin is the external clock.
// R21 - Option byte selects external, five crystal settings or RC.
// R22 - Software recalibrates trim when voltage or temperature changes.
// R23 - Enabled PLL outputs its clock only after a start-up delay.
// R24 - Selection static after reset, glitch-free, gated until settled.
module csp_top import csp_pkg::*; #(
	parameter int STARTUP_CYC = CSP_STARTUP_CYC,
	parameter logic [7:0] CAL5_HI = 8'h80,
	parameter logic [1:0] CAL5_LO = 2'h0,
	parameter logic [7:0] CAL33_HI = 8'h80,
	parameter logic [1:0] CAL33_LO = 2'h0
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Option byte and mode
	input wire csp_opt_s opt,
	input wire logic icc_rc_mode,
	// Source ticks from oscillators and PLL
	input wire logic rc_tick,
	input wire logic xtal_tick,
	input wire logic ext_tick,
	input wire logic pin_tick,
	input wire logic pll_tick,
	input wire logic pll_at_freq,
	input wire logic tpll_tick,
	// Oscillator and PLL controls
	output logic [9:0] rc_trim,
	output logic rc_enable,
	output logic xtal_enable,
	output logic pll_enable,
	output logic pll_x8,
	output logic pll_half,
	output logic tpll_enable,
	output logic tpll_in_tick,
	output logic timer_tick,
	// Clock outputs
	output logic osc_tick,
	output logic cpu_tick,
	output logic clock_output_enable,
	output logic clock_out_tick
);
	// ==========================================================
	// Input synchronisers
	logic [7:0] sync1;
	logic [7:0] sync2;
	logic [7:0] sync3;
	// No reset, so the mode pin has settled when options are taken
	always_ff @(posedge aclk) begin
		sync1 <= {pll_tick, icc_rc_mode, rc_tick, xtal_tick, ext_tick, pin_tick, pll_at_freq,
			tpll_tick};
		sync2 <= sync1;
		sync3 <= sync2;
	end
	logic icc_s;
	logic [7:0] rise;
	assign icc_s = sync2[6];
	assign rise = sync2 & ~sync3;
	// ==========================================================
	// Static option capture
	csp_opt_s opt_q;
	logic opt_taken;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			opt_taken <= 1'b0;
			opt_q <= '{src: CSP_SRC_PIN, pll_en: 1'b0, pll_x8: 1'b0, tpll_en: 1'b0,
				ext16: 1'b0};
		end else if (!opt_taken) begin
			opt_taken <= 1'b1;
			opt_q <= opt; // see R24
			if (icc_s) begin
				opt_q.src <= CSP_SRC_RC; // see R17
			end
		end
	end
	function automatic logic csp_is_xtal(input csp_src_e s);
		csp_is_xtal = (s >= CSP_SRC_XTAL0) && (s <= CSP_SRC_XTAL4); // see R21
	endfunction
	// ==========================================================
	// Registers
	logic [7:0] main_clock_ctrl_status;
	logic [7:0] rc_trim_high;
	logic [1:0] trim_lower_bits;
	logic pll_halving_bit;
	logic pll_settled_flag;
	logic aw_ok;
	logic w_ok;
	logic [7:0] aw_q;
	logic [31:0] w_q;
	logic [3:0] ws_q;
	logic wr_go;
	assign wr_go = aw_ok && w_ok && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok <= 1'b0;
			w_ok <= 1'b0;
			aw_q <= '0;
			w_q <= '0;
			ws_q <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= CSP_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_ok && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_ok && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok <= 1'b1;
				aw_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok <= 1'b1;
				w_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_ok <= 1'b0;
				w_ok <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_q <= CSP_OFF_STATUS && aw_q[1:0] == 2'h0) ?
					CSP_RESP_OKAY : CSP_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			main_clock_ctrl_status <= CSP_MAIN_RST; // see R13
			rc_trim_high <= CSP_TRIM_RST; // see R02
			trim_lower_bits <= CSP_TRIM_LO_RST;
			pll_halving_bit <= 1'b0;
		end else if (wr_go && ws_q[0]) begin
			unique case (aw_q)
				CSP_OFF_MAIN: main_clock_ctrl_status <= w_q[7:0] & CSP_MAIN_WMASK; // see R13
				CSP_OFF_TRIM: rc_trim_high <= w_q[7:0]; // see R01
				CSP_OFF_SUPPLY: trim_lower_bits <= w_q[CSP_SUP_TRIM_LSB +: 2]; // see R01
				CSP_OFF_PLL_TEST_REG: pll_halving_bit <= w_q[CSP_PLL_TEST_REG_HALF];
				default: ;
			endcase
		end
	end
	// ==========================================================
	// Read channel
	logic [7:0] rd_byte;
	logic rd_ok;
	always_comb begin
		rd_byte = 8'h00;
		rd_ok = 1'b1;
		unique case (s_axi_araddr)
			CSP_OFF_MAIN: rd_byte = main_clock_ctrl_status;
			CSP_OFF_TRIM: rd_byte = rc_trim_high;
			CSP_OFF_SUPPLY: rd_byte = {1'b0, trim_lower_bits, 4'h0, pll_settled_flag};
			CSP_OFF_PLL_TEST_REG: rd_byte = {7'h00, pll_halving_bit};
			CSP_OFF_CAL5_HI: rd_byte = CAL5_HI; // see R04
			CSP_OFF_CAL5_LO: rd_byte = csp_lo_byte(CAL5_LO); // see R05
			CSP_OFF_CAL33_HI: rd_byte = CAL33_HI; // see R04
			CSP_OFF_CAL33_LO: rd_byte = csp_lo_byte(CAL33_LO); // see R05
			CSP_OFF_STATUS: rd_byte = {5'h00, opt_q.src};
			default: rd_ok = 1'b0;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= CSP_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rd_byte};
				s_axi_rresp <= rd_ok ? CSP_RESP_OKAY : CSP_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
	// ==========================================================
	// PLL start-up and settle state
	csp_pll_e pll_st;
	logic [15:0] pll_cnt;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pll_st <= CSP_ST_OFF;
			pll_cnt <= '0;
			pll_settled_flag <= 1'b0;
		end else begin
			unique case (pll_st)
				CSP_ST_OFF: begin
					if (opt_taken && opt_q.pll_en) begin
						pll_st <= CSP_ST_WAIT;
					end
				end
				CSP_ST_WAIT: begin
					if (pll_cnt == 16'(STARTUP_CYC - 1)) begin
						if (sync2[1]) begin
							pll_st <= CSP_ST_LOCK; // see R23
							pll_settled_flag <= 1'b1; // see R09
						end
					end else begin
						pll_cnt <= pll_cnt + 16'h0001;
					end
				end
				CSP_ST_LOCK: pll_settled_flag <= 1'b1;
				default: pll_st <= CSP_ST_OFF;
			endcase
		end
	end
	// ==========================================================
	// Source mux, glitch-free by per-tick selection
	logic src_tick;
	logic pll_gate;
	logic half_tog;
	assign pll_gate = pll_st == CSP_ST_LOCK; // see R24
	always_comb begin
		src_tick = 1'b0;
		if (!opt_taken) begin
			src_tick = 1'b0;
		end else if (opt_q.pll_en) begin
			src_tick = pll_gate && (pll_halving_bit && opt_q.pll_x8 ? half_tog : 1'b1) &&
				rise[7]; // see R06 R10
		end else if (opt_q.src == CSP_SRC_RC) begin
			src_tick = rise[5]; // see R07
		end else if (csp_is_xtal(opt_q.src)) begin
			src_tick = rise[4]; // see R19
		end else if (opt_q.src == CSP_SRC_EXT) begin
			src_tick = rise[3]; // see R08
		end else begin
			src_tick = rise[2]; // see R20
		end
	end
	// Halving of the PLL tick stream
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			half_tog <= 1'b0;
		end else if (rise[7]) begin
			half_tog <= !half_tog; // see R10
		end
	end
	// ==========================================================
	// Slow mode and clock outputs
	logic slow_tick;
	csp_divider #(.DIV(CSP_SLOW_DIV), .W(CSP_DIV_W)) u_slow (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick_in(src_tick),
		.tick_out(slow_tick)
	);
	logic tdiv;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_tick <= 1'b0;
			cpu_tick <= 1'b0;
			clock_out_tick <= 1'b0;
			clock_output_enable <= 1'b0;
			tdiv <= 1'b0;
			tpll_in_tick <= 1'b0;
			timer_tick <= 1'b0;
		end else begin
			osc_tick <= src_tick;
			cpu_tick <= main_clock_ctrl_status[CSP_MAIN_SLOW] ? slow_tick : src_tick; // see R15
			clock_output_enable <= main_clock_ctrl_status[CSP_MAIN_CLKOUT]; // see R14
			clock_out_tick <= main_clock_ctrl_status[CSP_MAIN_CLKOUT] &&
				(main_clock_ctrl_status[CSP_MAIN_SLOW] ? slow_tick : src_tick); // see R14
			if (src_tick) begin
				tdiv <= !tdiv;
			end
			tpll_in_tick <= opt_q.tpll_en && src_tick && (!opt_q.ext16 || tdiv); // see R12
			timer_tick <= opt_q.tpll_en && rise[0]; // see R11
		end
	end
	// ==========================================================
	// Control outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rc_trim <= {CSP_TRIM_RST, CSP_TRIM_LO_RST};
			rc_enable <= 1'b0;
			xtal_enable <= 1'b1;
			pll_enable <= 1'b0;
			pll_x8 <= 1'b0;
			pll_half <= 1'b0;
			tpll_enable <= 1'b0;
		end else begin
			rc_trim <= {rc_trim_high, trim_lower_bits}; // see R01 R03
			rc_enable <= opt_q.src == CSP_SRC_RC;
			xtal_enable <= !opt_taken || csp_is_xtal(opt_q.src); // see R19
			pll_enable <= opt_q.pll_en; // see R06
			pll_x8 <= opt_q.pll_x8;
			pll_half <= pll_halving_bit;
			tpll_enable <= opt_q.tpll_en; // see R11
		end
	end
	// ==========================================================
	// Assertions
	a_main_reserved: assert property (@(posedge aclk) disable iff (!aresetn) // see R13
		main_clock_ctrl_status[7:2] == 6'h00) else $error("main reserved bits set");
	a_trim_reset: assert property (@(posedge aclk) $rose(aresetn) |-> // see R02
		rc_trim_high == 8'hFF) else $error("trim not FFh after reset");
	a_trim_out: assert property (@(posedge aclk) disable iff (!aresetn) // see R01
		##1 rc_trim == {$past(rc_trim_high), $past(trim_lower_bits)}) else
		$error("trim output mismatch");
	a_settle_gate: assert property (@(posedge aclk) disable iff (!aresetn) // see R24
		opt_q.pll_en && !pll_settled_flag |-> !src_tick) else $error("PLL clock before settle");
	a_settle_delay: assert property (@(posedge aclk) disable iff (!aresetn) // see R23
		$rose(pll_settled_flag) |-> pll_cnt == 16'(STARTUP_CYC - 1)) else
		$error("settle before start-up delay");
	a_settle_freq: assert property (@(posedge aclk) disable iff (!aresetn) // see R09
		$rose(pll_settled_flag) |-> $past(sync2[1])) else $error("settle without lock");
	a_clkout_gate: assert property (@(posedge aclk) disable iff (!aresetn) // see R14
		!clock_output_enable |-> !clock_out_tick) else $error("clock out while disabled");
	a_slow_mode: assert property (@(posedge aclk) disable iff (!aresetn) // see R15
		main_clock_ctrl_status[CSP_MAIN_SLOW] && $stable(main_clock_ctrl_status) |=>
		cpu_tick == $past(slow_tick)) else $error("slow mode not divided");
	a_lo_layout: assert property (@(posedge aclk) disable iff (!aresetn) // see R05
		s_axi_arvalid && s_axi_arready && s_axi_araddr == CSP_OFF_CAL5_LO |=>
		s_axi_rdata[7:0] == {1'b0, CAL5_LO, 5'h00}) else $error("low trim layout wrong");
	c_write_main: cover property (@(posedge aclk) wr_go && aw_q == CSP_OFF_MAIN);
	c_pll_settle: cover property (@(posedge aclk) $rose(pll_settled_flag));
	c_slow_tick: cover property (@(posedge aclk) cpu_tick && main_clock_ctrl_status[0]);
endmodule

//--- test/csp_osc_model.sv
// Purpose: Behavioural oscillators, PLL and timer PLL feeding the clock block
// Assumes: Source clocks are slow levels sampled on aclk
// Notes: Disabled sources stand still; external and pin clocks run free
module csp_osc_model #(
	parameter int LOCK_CYC = 20
) (
	// Clock
	input wire logic aclk,
	// Enables from the block
	input wire logic rc_enable,
	input wire logic xtal_enable,
	input wire logic pll_enable,
	input wire logic tpll_enable,
	// Source levels
	output logic rc_tick,
	output logic xtal_tick,
	output logic ext_tick,
	output logic pin_tick,
	output logic pll_tick,
	output logic tpll_tick,
	output logic pll_at_freq
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Free dividers per source
	int half[0:5] = '{20, 12, 16, 14, 5, 3};
	int cnt[0:5] = '{0, 0, 0, 0, 0, 0};
	int lock_cnt = 0;
	logic [5:0] lvl = 6'h00;
	logic [5:0] en;
	assign en = {tpll_enable, pll_enable, 2'b11, xtal_enable, rc_enable};
	assign {tpll_tick, pll_tick, pin_tick, ext_tick, xtal_tick, rc_tick} = lvl;
	assign pll_at_freq = (lock_cnt >= LOCK_CYC);
	always @(posedge aclk) begin
		for (int i = 0; i < 6; i++) begin
			if (en[i]) begin
				if (cnt[i] >= half[i] - 1) begin
					cnt[i] <= 0;
					lvl[i] <= ~lvl[i];
				end else begin
					cnt[i] <= cnt[i] + 1;
				end
			end
		end
		lock_cnt <= pll_enable ? lock_cnt + 1 : 0;
	end
endmodule

//--- test/tb_top.sv
// Purpose: Register and clock routing tests for the clock source block
// Assumes: AXI4-Lite master tasks, STARTUP_CYC shortened to 4
// Notes: Tick counts compared with small tolerance for pipeline delay
module tb_top import csp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Signals
	logic aclk = 0, aresetn = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	csp_opt_s opt = '0;
	logic in_circuit_programming = 0;
	logic rc_t, xt_t, ex_t, pn_t, pl_t, tp_t, at_freq;
	logic [9:0] rc_trim;
	logic rc_en, xt_en, pl_en, pl_x8, pl_half, tp_en, tin, tmr, osc, cpu, coe, cout;
	int fail_count = 0, total_checks = 0, cyc = 0;
	int cnt[0:10] = '{default: 0};
	int base[0:10];
	logic [10:0] lv, lv_q = '0;
	logic [1:0] rsp;
	logic [31:0] rd;
	always #2.5 aclk = ~aclk;
	csp_top #(.STARTUP_CYC(4), .CAL5_HI(8'hA5), .CAL5_LO(2'h2), .CAL33_HI(8'h5A),
		.CAL33_LO(2'h1)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .opt(opt), .icc_rc_mode(in_circuit_programming), .rc_tick(rc_t),
		.xtal_tick(xt_t), .ext_tick(ex_t), .pin_tick(pn_t), .pll_tick(pl_t),
		.pll_at_freq(at_freq), .tpll_tick(tp_t), .rc_trim(rc_trim), .rc_enable(rc_en),
		.xtal_enable(xt_en), .pll_enable(pl_en), .pll_x8(pl_x8), .pll_half(pl_half),
		.tpll_enable(tp_en), .tpll_in_tick(tin), .timer_tick(tmr), .osc_tick(osc),
		.cpu_tick(cpu), .clock_output_enable(coe), .clock_out_tick(cout));
	csp_osc_model model (.aclk(aclk), .rc_enable(rc_en), .xtal_enable(xt_en),
		.pll_enable(pl_en), .tpll_enable(tp_en), .rc_tick(rc_t), .xtal_tick(xt_t),
		.ext_tick(ex_t), .pin_tick(pn_t), .pll_tick(pl_t), .tpll_tick(tp_t),
		.pll_at_freq(at_freq));
	// ==========================================================
	// Tick counters: rises of source levels, pulses of block outputs
	assign lv = {cout, tmr, tin, cpu, osc, tp_t, pl_t, pn_t, ex_t, xt_t, rc_t};
	always @(posedge aclk) begin
		lv_q <= lv;
		for (int i = 0; i < 11; i++)
			cnt[i] <= cnt[i] + ((i < 6) ? int'(lv[i] & ~lv_q[i]) : int'(lv[i]));
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fail_count++;
			report_and_stop();
		end
	end
	// ==========================================================
	// Checks and closing
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic near(input int got, input int exp);
		chk(32'((got > exp + 2 || got < exp - 2) ? got : exp), 32'(exp));
	endtask
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ==========================================================
	// AXI4-Lite master
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		forever begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid) begin
				r = bresp;
				bready <= 0;
				break;
			end
		end
	endtask
	task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		forever begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 0;
				break;
			end
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rdr(a, rd, rsp);
		chk({rsp, rd}, {CSP_RESP_OKAY, exp});
	endtask
	// ==========================================================
	// Reset with options, then measure routed ticks
	task automatic start(input csp_src_e s, input logic [3:0] pll_bits, input logic f);
		@(posedge aclk);
		aresetn <= 0;
		opt <= '{src: s, pll_en: pll_bits[3], pll_x8: pll_bits[2], tpll_en: pll_bits[1],
			ext16: pll_bits[0]};
		in_circuit_programming <= f;
		repeat (10) @(posedge aclk);
		chk({22'h0, rc_trim}, 32'h3FC);
		chk(32'(xt_en), 32'h1);
		aresetn <= 1;
	endtask
	task automatic measure(input int w);
		@(negedge aclk);
		base = cnt;
		repeat (w) @(negedge aclk);
		for (int i = 0; i < 11; i++)
			base[i] = cnt[i] - base[i];
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		start(CSP_SRC_RC, 4'h0, 0);
		rchk(CSP_OFF_MAIN, 32'h00);
		rchk(CSP_OFF_TRIM, 32'hFF);
		measure(640);
		near(base[6], base[0]);
		near(base[7], base[6]);
		chk(32'(base[10]), 32'h0);
		wr(CSP_OFF_MAIN, 32'hFE, rsp);
		rchk(CSP_OFF_MAIN, 32'h02);
		chk(32'(coe), 32'h1);
		measure(640);
		near(base[10], base[6]);
		wr(CSP_OFF_TRIM, 32'h80, rsp);
		wr(CSP_OFF_SUPPLY, 32'h61, rsp);
		rchk(CSP_OFF_SUPPLY, 32'h60);
		chk({22'h0, rc_trim}, 32'h203);
		rchk(CSP_OFF_CAL5_HI, 32'hA5);
		rchk(CSP_OFF_CAL5_LO, 32'h40);
		rchk(CSP_OFF_CAL33_HI, 32'h5A);
		rchk(CSP_OFF_CAL33_LO, 32'h20);
		wr(CSP_OFF_CAL5_HI, 32'h00, rsp);
		rchk(CSP_OFF_CAL5_HI, 32'hA5);
		wr(8'h24, 32'h01, rsp);
		chk(32'(rsp), 32'(CSP_RESP_SLVERR));
		rdr(8'h02, rd, rsp);
		chk(32'(rsp), 32'(CSP_RESP_SLVERR));
		start(CSP_SRC_EXT, 4'h3, 0);
		rchk(CSP_OFF_TRIM, 32'hFF);
		wstrb <= 4'h0;
		wr(CSP_OFF_TRIM, 32'h11, rsp);
		chk(32'(rsp), 32'(CSP_RESP_OKAY));
		rchk(CSP_OFF_TRIM, 32'hFF);
		wstrb <= 4'hF;
		wr(CSP_OFF_TRIM, 32'h40, rsp);
		rchk(CSP_OFF_TRIM, 32'h40);
		measure(640);
		near(base[6], base[2]);
		chk(32'(tp_en), 32'h1);
		near(base[8], base[2] / 2);
		near(base[9], base[5]);
		start(CSP_SRC_PIN, 4'h0, 0);
		measure(640);
		near(base[6], base[3]);
		start(CSP_SRC_EXT, 4'h0, 1);
		measure(640);
		near(base[6], base[0]);
		chk(32'(rc_en), 32'h1);
		start(CSP_SRC_XTAL2, 4'h0, 0);
		rchk(CSP_OFF_STATUS, 32'h3);
		measure(640);
		near(base[6], base[1]);
		start(CSP_SRC_RC, 4'hC, 0);
		rchk(CSP_OFF_SUPPLY, 32'h00);
		chk({30'h0, pl_en, pl_x8}, 32'h3);
		measure(640);
		rchk(CSP_OFF_SUPPLY, 32'h01);
		near(base[6], base[4] - 4);
		wr(CSP_OFF_PLL_TEST_REG, 32'h01, rsp);
		rchk(CSP_OFF_PLL_TEST_REG, 32'h01);
		chk(32'(pl_half), 32'h1);
		wr(CSP_OFF_MAIN, 32'h01, rsp);
		measure(3200);
		near(base[7], base[6] / CSP_SLOW_DIV);
		near(base[6], base[4] / 2);
		report_and_stop();
	end
endmodule
